// ---- design/idmd_decoder.v ----
// Purpose: Decode core accesses to internal RAM, special function space and register banks.
// Assumes: The core holds each request for one cycle and reads data one cycle later.
// Notes:   Program store sector numbers are derived for the flash controller.
`timescale 1ns/1ps
`default_nettype none
`include "idmd_consts.vh"
module idmd_decoder
(
  input  wire                           clk_sys,
  input  wire                           rst_b,
  input  wire                           req,
  input  wire                           req_write,
  input  wire                           req_indirect,
  input  wire                           req_bit,
  input  wire                           req_reg,
  input  wire [`IDMD_BANK_W-1:0]        reg_bank,
  input  wire [`IDMD_REGNUM_W-1:0]      reg_num,
  input  wire [`IDMD_RAM_AW-1:0]        req_addr,
  input  wire [`IDMD_DW-1:0]            req_wdata,
  input  wire                           req_bit_value,
  input  wire [`IDMD_PROG_AW-1:0]       prog_addr,
  output wire                           sfs_req,
  output wire                           sfs_write,
  output wire [`IDMD_SFS_AW-1:0]        sfs_addr,
  output wire [`IDMD_DW-1:0]            sfs_wdata,
  input  wire [`IDMD_DW-1:0]            sfs_rdata,
  output reg  [`IDMD_DW-1:0]            rd_data,
  output reg                            rd_bit,
  output reg                            rd_valid,
  output wire                           bit_addr_err,
  output wire [`IDMD_SECTOR_AW-1:0]     prog_sector,
  output wire [`IDMD_SECTOR_OFF_AW-1:0] prog_sector_off
);

  ////////////////////////////////////////////////////////////////////////
  // Bit write sequencer states.
  ////////////////////////////////////////////////////////////////////////
  localparam [`IDMD_ST_W-1:0] ST_IDLE  = `IDMD_ST_IDLE;
  localparam [`IDMD_ST_W-1:0] ST_MERGE = `IDMD_ST_MERGE;

  ////////////////////////////////////////////////////////////////////////
  // Address arithmetic.
  ////////////////////////////////////////////////////////////////////////
  // Register bank and number give a byte in the first 32 bytes.
  function [`IDMD_RAM_AW-1:0] reg_byte;
    input [`IDMD_BANK_W-1:0]   bank;
    input [`IDMD_REGNUM_W-1:0] num;
    begin
      reg_byte = {{(`IDMD_RAM_AW-`IDMD_BANK_W-`IDMD_REGNUM_W){1'h0}}, bank, num};
    end
  endfunction

  // A bit address selects one byte above the register banks.
  function [`IDMD_RAM_AW-1:0] bit_byte;
    input [`IDMD_RAM_AW-1:0] baddr;
    begin
      bit_byte = `IDMD_BIT_BASE + {{`IDMD_BITIDX_LSB{1'h0}}, baddr[`IDMD_RAM_AW-1:`IDMD_BITIDX_LSB]};
    end
  endfunction

  // A bit address is legal only up to the last bit of the bit-addressable bytes.
  function bit_legal;
    input [`IDMD_RAM_AW-1:0] baddr;
    begin
      bit_legal = (baddr <= `IDMD_BITADDR_TOP);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Target decode.
  ////////////////////////////////////////////////////////////////////////
  reg  [`IDMD_ST_W-1:0]   state;
  reg  [`IDMD_ST_W-1:0]   next_state;
  wire                    merging;
  wire                    bit_ok;
  wire                    upper;
  wire                    to_sfs;
  wire                    to_ram;
  wire                    bit_wr;
  wire [`IDMD_RAM_AW-1:0] ram_addr;

  // Only direct byte accesses to the upper half leave the RAM.
  assign merging  = (state == ST_MERGE);
  assign bit_ok   = bit_legal(req_addr);
  assign upper    = req_addr[`IDMD_UPPER_BIT];
  assign to_sfs   = req & ~req_reg & ~req_bit & ~req_indirect & upper;
  assign to_ram   = req & ~to_sfs & (~req_bit | bit_ok);
  assign bit_wr   = to_ram & req_bit & req_write & ~merging;
  assign ram_addr = req_reg ? reg_byte(reg_bank, reg_num)
                  : (req_bit ? bit_byte(req_addr) : req_addr);

  assign sfs_req      = to_sfs;
  assign sfs_write    = to_sfs & req_write;
  assign sfs_addr     = req_addr[`IDMD_SFS_AW-1:0];
  assign sfs_wdata    = req_wdata;
  assign bit_addr_err = req & req_bit & ~bit_ok;

  ////////////////////////////////////////////////////////////////////////
  // Bit writes read the byte first, then write it back merged.
  ////////////////////////////////////////////////////////////////////////
  // A bit write holds the RAM port for one more cycle.
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (bit_wr)
        begin
          next_state = ST_MERGE;
        end
      end
      ST_MERGE:
      begin
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  reg  [`IDMD_RAM_AW-1:0]   rmw_addr;
  reg  [`IDMD_BITPOS_W-1:0] rmw_pos;
  reg                       rmw_val;
  wire [`IDMD_DW-1:0]       ram_rdata;
  reg  [`IDMD_DW-1:0]       merged;
  wire                      ram_we;
  wire [`IDMD_RAM_AW-1:0]   ram_a;
  wire [`IDMD_DW-1:0]       ram_wd;

  // The new bit replaces one bit of the byte read in the cycle before.
  always @*
  begin
    merged          = ram_rdata;
    merged[rmw_pos] = rmw_val;
  end

  assign ram_we = merging | (to_ram & req_write & ~req_bit);
  assign ram_a  = merging ? rmw_addr : ram_addr;
  assign ram_wd = merging ? merged : req_wdata;

  idmd_ram u_ram
  (
    .clk_sys (clk_sys),
    .we      (ram_we),
    .addr    (ram_a),
    .wdata   (ram_wd),
    .rdata   (ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state and read return registers.
  ////////////////////////////////////////////////////////////////////////
  reg                       pend_rd;
  reg                       pend_sfs;
  reg                       pend_bit;
  reg  [`IDMD_BITPOS_W-1:0] pend_pos;
  reg  [`IDMD_DW-1:0]       sfs_hold;

  // A read in the merge cycle is dropped, since the RAM port is busy then.
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state    <= ST_IDLE;
      rmw_addr <= `IDMD_ZERO_BYTE;
      rmw_pos  <= `IDMD_ZERO_POS;
      rmw_val  <= 1'h0;
      pend_rd  <= 1'h0;
      pend_sfs <= 1'h0;
      pend_bit <= 1'h0;
      pend_pos <= `IDMD_ZERO_POS;
      sfs_hold <= `IDMD_ZERO_BYTE;
    end
    else
    begin
      state    <= next_state;
      rmw_addr <= ram_addr;
      rmw_pos  <= req_addr[`IDMD_BITPOS_W-1:0];
      rmw_val  <= req_bit_value;
      pend_rd  <= req & ~req_write & ~merging & ~bit_addr_err;
      pend_sfs <= to_sfs;
      pend_bit <= req_bit;
      pend_pos <= req_addr[`IDMD_BITPOS_W-1:0];
      sfs_hold <= sfs_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data return.
  ////////////////////////////////////////////////////////////////////////
  // The answer stands for exactly the cycle after the request.
  always @*
  begin
    rd_data  = pend_sfs ? sfs_hold : ram_rdata;
    rd_valid = pend_rd;
    rd_bit   = 1'h0;
    if (pend_bit)
    begin
      rd_bit = rd_data[pend_pos];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program store sector split.
  ////////////////////////////////////////////////////////////////////////
  // The sector number is the address above the offset bits of a sector.
  assign prog_sector     = prog_addr[`IDMD_PROG_AW-1:`IDMD_SECTOR_OFF_AW];
  assign prog_sector_off = prog_addr[`IDMD_SECTOR_OFF_AW-1:0];
endmodule
`default_nettype wire

// ---- design/idmd_consts.vh ----
// Purpose: Constants for the internal data memory decoder.
// Assumes: 8-bit data space addresses, byte-wide data.
// Notes:   Included by the decoder and its memory.
`ifndef IDMD_CONSTS_VH
`define IDMD_CONSTS_VH
`define IDMD_RAM_DEPTH      256
`define IDMD_RAM_AW         8
`define IDMD_DW             8
`define IDMD_SFS_AW         7
`define IDMD_UPPER_BIT      7
`define IDMD_BANK_MSB       4
`define IDMD_REG_TOP        8'h1F
`define IDMD_BIT_BASE       8'h20
`define IDMD_BIT_TOP        8'h2F
`define IDMD_BITADDR_TOP    8'h7F
`define IDMD_BIT_BASE_IDX   4'h4
`define IDMD_BANK_W         2
`define IDMD_REGNUM_W       3
`define IDMD_BITPOS_W       3
`define IDMD_BITIDX_LSB     3
`define IDMD_ZERO_BYTE      8'h00
`define IDMD_ZERO_POS       3'h0
`define IDMD_ST_W           2
`define IDMD_ST_IDLE        2'h1
`define IDMD_ST_MERGE       2'h2
`define IDMD_PROG_AW        14
`define IDMD_SECTOR_AW      5
`define IDMD_SECTOR_OFF_AW  9
`endif

// ---- design/idmd_ram.v ----
// Purpose: Byte-wide single-port data RAM with registered read data.
// Assumes: One access per cycle; write and read share one address.
// Notes:   Read data appear one cycle after the request.
`timescale 1ns/1ps
`default_nettype none
`include "idmd_consts.vh"
module idmd_ram
(
  input  wire                        clk_sys,
  input  wire                        we,
  input  wire [`IDMD_RAM_AW-1:0]     addr,
  input  wire [`IDMD_DW-1:0]         wdata,
  output reg  [`IDMD_DW-1:0]         rdata
);
  reg [`IDMD_DW-1:0] mem [0:`IDMD_RAM_DEPTH-1];

  always @(posedge clk_sys)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

// ---- test/idmd_model.sv ----
// Purpose: Special function space responder.
// Assumes: Data sampled in the request cycle.
// Notes:   Unselected data toggle every half cycle.
`timescale 1ns/1ps
`default_nettype none
module idmd_model
(
  input  wire logic       clk_sys,
  input  wire logic       sfs_req,
  input  wire logic [6:0] sfs_addr,
  output logic      [7:0] sfs_rdata
);
  assign sfs_rdata = sfs_req ? {1'h0, sfs_addr} ^ 8'h5A : {8{clk_sys}};
endmodule
`default_nettype wire

// ---- test/idmd_chk.sv ----
// Purpose: Port assertions for the decoder.
// Assumes: One clock, reset active low.
// Notes:   Bound to the decoder.
`timescale 1ns/1ps
`default_nettype none
module idmd_chk
(
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        req,
  input wire logic        req_write,
  input wire logic        req_indirect,
  input wire logic        req_bit,
  input wire logic        req_reg,
  input wire logic        sfs_req,
  input wire logic        rd_valid,
  input wire logic        bit_addr_err,
  input wire logic [7:0]  req_addr,
  input wire logic [7:0]  sfs_rdata,
  input wire logic [7:0]  rd_data,
  input wire logic [6:0]  sfs_addr,
  input wire logic [13:0] prog_addr,
  input wire logic [4:0]  prog_sector,
  input wire logic [8:0]  prog_sector_off
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire up = req && !req_indirect && !req_bit && !req_reg && req_addr[7];
  a_upper_to_space: assert property (up |-> sfs_req) else $error("no space select");
  a_ram_no_space: assert property (req && !up |-> !sfs_req) else $error("stray select");
  a_space_addr: assert property (sfs_req |-> sfs_addr == req_addr[6:0]) else $error("bad address");
  a_read_answer: assert property (req && !req_write && !bit_addr_err |=> rd_valid) else $error("no answer");
  a_write_quiet: assert property (req && req_write |=> !rd_valid) else $error("write answered");
  a_space_data: assert property (sfs_req && !req_write |=> rd_data == $past(sfs_rdata)) else $error("bad data");
  a_bit_range: assert property (req && req_bit |-> bit_addr_err == req_addr[7]) else $error("bad flag");
  a_sector_split: assert property ({prog_sector, prog_sector_off} == prog_addr) else $error("bad split");
  c_space: cover property (sfs_req && !req_write);
  c_bit_err: cover property (bit_addr_err);
  c_bit: cover property (req && req_bit && req_write);
  c_reg: cover property (req && req_reg);
endmodule
bind idmd_decoder idmd_chk u_chk (.*);
`default_nettype wire

// ---- test/idmd_decoder_tb.sv ----
// Purpose: Self-checking bench for the decoder.
// Assumes: One access per two cycles.
// Notes:   Row is {write, indirect, bit, reg, addr, data}.
`timescale 1ns/1ps
`default_nettype none
module idmd_decoder_tb;
  logic clk_sys = 0, rst_b = 0, req = 0, rw = 0, ri = 0, rb = 0, rr = 0, bv = 0, sq, sw, rbit, rv, be;
  logic [7:0] ra = 0, wd = 0, sd, swd, rd;
  logic [13:0] pa = 14'h3E01;
  logic [6:0] sa;
  logic [4:0] ps;
  logic [8:0] po;
  int bad_count = 0, n_checks = 0, cyc = 0;
  logic [19:0] rows [0:16] = '{20'hC8511, 20'h81022, 20'hC0033, 20'hCFF44, 20'h88599, 20'h48511,
    20'h0855F, 20'h41022, 20'h0FF25, 20'h00033, 20'h4FF44, 20'h91566, 20'h41566, 20'h11566,
    20'h82100, 20'hA0B01, 20'h02108};
  idmd_decoder DUT (.clk_sys, .rst_b, .req, .req_write(rw), .req_indirect(ri), .req_bit(rb),
    .req_reg(rr), .reg_bank(ra[4:3]), .reg_num(ra[2:0]), .req_addr(ra), .req_wdata(wd),
    .req_bit_value(bv), .prog_addr(pa), .sfs_req(sq), .sfs_write(sw), .sfs_addr(sa), .sfs_wdata(swd),
    .sfs_rdata(sd), .rd_data(rd), .rd_bit(rbit), .rd_valid(rv), .bit_addr_err(be),
    .prog_sector(ps), .prog_sector_off(po));
  idmd_model u_model (.clk_sys, .sfs_req(sq), .sfs_addr(sa), .sfs_rdata(sd));
  task automatic conclude;
    if (bad_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic acc(input logic [19:0] r);
    {rw, ri, rb, rr, ra, wd} = r;
    bv = r[0];
    req = 1;
    #1 chk({sq, sw}, {~(ri | rb | rr) & ra[7], rw & ~(ri | rb | rr) & ra[7]});
    if (sw) chk({sa, swd}, {ra[6:0], wd});
    @(negedge clk_sys) req = 0;
    if (!rw) chk({rv, 7'h0, rb ? {7'h0, rbit} : rd}, {8'h80, r[7:0]});
    if (!rw && !rb) chk(rbit, 1'h0);
    @(negedge clk_sys);
  endtask
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (++cyc > 500) begin bad_count++; conclude(); end
  initial
  begin
    repeat (3) @(negedge clk_sys);
    chk(rv, 0);
    rst_b = 1;
    @(negedge clk_sys);
    foreach (rows[i]) acc(rows[i]);
    acc(20'h20B01);
    {rw, ri, rb, rr, ra} = 12'h085;
    req = 1;
    @(negedge clk_sys) req = 0;
    rst_b = 0;
    #1 chk(rv, 0);
    @(negedge clk_sys) rst_b = 1;
    acc(20'h0855F);
    {rw, ri, rb, rr, ra} = 12'h280;
    req = 1;
    #1 chk(be, 1);
    @(negedge clk_sys) req = 0;
    chk({2'h0, ps, po}, 16'h3E01);
    chk(ps, 5'h1F);
    pa = 14'h0200;
    #1 chk(ps, 5'h01);
    chk(po, 9'h000);
    @(negedge clk_sys);
    conclude();
  end
endmodule
`default_nettype wire
